// ===== core/sepc_defs.vh
`ifndef SEPC_DEFS_VH
`define SEPC_DEFS_VH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SEPC_OP_READ 2'b10
`define SEPC_OP_ERASE 2'b11
`define SEPC_OP_WRITE 2'b01
`define SEPC_OP_EXT 2'b00
`define SEPC_EXT_ENABLE 2'b11
`define SEPC_EXT_DISABLE 2'b00
`define SEPC_EXT_ERASE_ALL 2'b10
`define SEPC_EXT_WRITE_ALL 2'b01
`define SEPC_HDR_BITS_X16 5'd11
`define SEPC_HDR_BITS_X8 5'd12
`define SEPC_DATA_BITS_X16 5'd16
`define SEPC_DATA_BITS_X8 5'd8
`define SEPC_ERASED_WORD 16'hFFFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define SEPC_CLK_PERIOD_NS 10
`define SEPC_PROGRAM_CYCLE_TIME_NS 5000000
`define SEPC_PROGRAM_CYCLE_CNT (`SEPC_PROGRAM_CYCLE_TIME_NS / `SEPC_CLK_PERIOD_NS)
`endif

// ===== core/sepc_sync.v
`timescale 1ns/1ps
module sepc_sync #(
  parameter W = 3
) (
  input wire sys_clk, // System clock
  input wire rst, // Synchronous reset
  input wire [W-1:0] async_in, // Pin levels
  output reg [W-1:0] sync_out // Levels after two flops
);
  reg [W-1:0] meta_r;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sepc_sync

// ===== core/sepc_top.v
// Function
// - Instruction frame is 11 bits in x16 mode, 12 bits in x8 mode.
// - Input bits are sampled on each rising serial clock edge.
// - Data out floats except during read data or busy status.
// - After cycle start and reselect, data out low while busy, high when ready.
// - Dummy one shifted in while polling floats data out on that edge; code floats it only once ready and ignores the dummy one while busy.
// - Frame: start one, 2-bit opcode, address, then write data.
// - Opcode 10 reads, 11 erases a word, 01 writes a word.
// - Opcode 00 subcodes: 11 enable, 00 disable, 10 erase all, 01 write all.
// - Read sends one zero dummy bit then word, most significant bit first.
// - Read data bits change on the rising serial clock edge.
// - Continued clocking reads next address, wrapping last to zero.
// - Only the first word of a burst gets the dummy zero.
// - Power-up disables programming; erase and write ignored until enabled.
// - Programming stays enabled until disable instruction or power loss.
// - Reads work whether programming is enabled or not.
// - Internal cycle starts on select falling edge after a complete frame.
// - Internal cycle completes on own timing without serial clocks.
// - Erase or write cycle finishes within 5 ms, then status is ready.
// - Word write overwrites the location without a prior erase.
// - Word erase sets every bit of the location to one.
// - Erase-all sets every bit of the array to one.
`timescale 1ns/1ps
`include "sepc_defs.vh"
module sepc_top #(
  parameter PROG_CYCLES = `SEPC_PROGRAM_CYCLE_CNT
) (
  input wire sys_clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire chip_select, // Chip select pin
  input wire serial_clock_in, // Serial clock pin
  input wire serial_data_in, // Serial data pin
  input wire word_width_select, // 1 = 256x16, 0 = 512x8
  output reg serial_data_out, // Serial data out level
  output reg serial_data_oe, // High while data out is driven
  output reg busy // High during internal programming cycle
);
  localparam S_IDLE = 4'b0001;
  localparam S_HDR = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_READ = 4'b1000;

  wire [2:0] pins_s;
  reg cs_d_r;
  reg sk_d_r;
  reg [3:0] state_r;
  reg [4:0] cnt_r;
  reg [11:0] hdr_r;
  reg [15:0] wdata_r;
  reg [15:0] rd_sh_r;
  reg [8:0] rd_addr_r;
  reg prog_en_r;
  reg pend_r;
  reg [1:0] pend_kind_r;
  reg [8:0] pend_addr_r;
  reg [15:0] pend_data_r;
  reg [31:0] timer_r;
  reg [8:0] sweep_r;
  reg sweeping_r;
  reg [1:0] job_r;
  reg [8:0] job_addr_r;
  reg [15:0] job_data_r;
  reg status_r;
  reg [7:0] mem [0:511];

  wire cs_s = pins_s[2];
  wire sk_s = pins_s[1];
  wire di_s = pins_s[0];
  wire sk_rise = sk_s & ~sk_d_r;
  wire cs_fall = cs_d_r & ~cs_s;
  wire cs_rise = cs_s & ~cs_d_r;
  wire org16 = word_width_select;
  wire [4:0] hdr_len = org16 ? `SEPC_HDR_BITS_X16 : `SEPC_HDR_BITS_X8;
  wire [4:0] dat_len = org16 ? `SEPC_DATA_BITS_X16 : `SEPC_DATA_BITS_X8;
  wire [11:0] hdr_nxt = {hdr_r[10:0], di_s};
  wire [1:0] opc_nxt = org16 ? hdr_nxt[9:8] : hdr_nxt[10:9];
  wire [8:0] adr_nxt = org16 ? {1'b0, hdr_nxt[7:0]} : hdr_nxt[8:0];
  wire [1:0] sub_nxt = org16 ? hdr_nxt[7:6] : hdr_nxt[8:7];
  wire [8:0] last_addr = org16 ? 9'h0FF : 9'h1FF;

  // ----------------------------------------
  // Memory access helpers
  // ----------------------------------------
  // x16 word n lives in bytes 2n (high) and 2n+1 (low)
  function [15:0] rd_word;
    input [8:0] a;
    input o16;
    begin
      if (o16)
        rd_word = {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
      else
        rd_word = {mem[a], 8'h00};
    end
  endfunction

  function [8:0] addr_inc;
    input [8:0] a;
    input [8:0] last;
    begin
      addr_inc = (a == last) ? 9'h000 : a + 9'h001;
    end
  endfunction

  wire [15:0] nxt_word = rd_word(addr_inc(rd_addr_r, last_addr), org16);

  sepc_sync #(
    .W(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({chip_select, serial_clock_in, serial_data_in}),
    .sync_out(pins_s)
  );

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      cs_d_r <= 1'b0;
      sk_d_r <= 1'b0;
      state_r <= S_IDLE;
      cnt_r <= 5'd0;
      hdr_r <= 12'h000;
      wdata_r <= 16'h0000;
      rd_sh_r <= 16'h0000;
      rd_addr_r <= 9'h000;
      prog_en_r <= 1'b0;
      pend_r <= 1'b0;
      pend_kind_r <= 2'b00;
      pend_addr_r <= 9'h000;
      pend_data_r <= 16'h0000;
      status_r <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end
    else
    begin
      cs_d_r <= cs_s;
      sk_d_r <= sk_s;
      if (!cs_s)
      begin
        // Partial frame dropped; a complete one is already latched in pend_r
        state_r <= S_IDLE;
        status_r <= 1'b0;
        serial_data_oe <= 1'b0;
      end
      else
      begin
        if (cs_rise && busy)
        begin
          status_r <= 1'b1;
          serial_data_oe <= 1'b1;
          serial_data_out <= 1'b0;
        end
        else if (status_r)
          serial_data_out <= ~busy;
        if (status_r && !busy && sk_rise && di_s)
        begin
          // Dummy one ends polling and doubles as the next start bit
          status_r <= 1'b0;
          serial_data_oe <= 1'b0;
          state_r <= S_HDR;
          hdr_r <= 12'h001;
          cnt_r <= 5'd1;
        end
        else if (sk_rise && !status_r)
        begin
          case (state_r)
            S_IDLE:
            begin
              if (di_s && !busy)
              begin
                state_r <= S_HDR;
                hdr_r <= 12'h001;
                cnt_r <= 5'd1;
              end
            end
            S_HDR:
            begin
              hdr_r <= hdr_nxt;
              cnt_r <= cnt_r + 5'd1;
              if (cnt_r + 5'd1 == hdr_len)
              begin
                cnt_r <= 5'd0;
                state_r <= S_IDLE;
                if (opc_nxt == `SEPC_OP_READ)
                begin
                  // Dummy zero leads the first word only
                  state_r <= S_READ;
                  serial_data_oe <= 1'b1;
                  serial_data_out <= 1'b0;
                  rd_sh_r <= rd_word(adr_nxt, org16);
                  rd_addr_r <= adr_nxt;
                end
                else if (opc_nxt == `SEPC_OP_WRITE)
                  state_r <= S_DATA;
                else if (opc_nxt == `SEPC_OP_ERASE)
                begin
                  pend_r <= prog_en_r;
                  pend_kind_r <= `SEPC_OP_ERASE;
                  pend_addr_r <= adr_nxt;
                  pend_data_r <= `SEPC_ERASED_WORD;
                end
                else if (sub_nxt == `SEPC_EXT_ENABLE)
                  prog_en_r <= 1'b1;
                else if (sub_nxt == `SEPC_EXT_DISABLE)
                  prog_en_r <= 1'b0;
                else if (sub_nxt == `SEPC_EXT_ERASE_ALL)
                begin
                  pend_r <= prog_en_r;
                  pend_kind_r <= `SEPC_EXT_ERASE_ALL;
                  pend_data_r <= `SEPC_ERASED_WORD;
                end
                else
                  state_r <= S_DATA;
              end
            end
            S_DATA:
            begin
              wdata_r <= {wdata_r[14:0], di_s};
              cnt_r <= cnt_r + 5'd1;
              if (cnt_r + 5'd1 == dat_len)
              begin
                state_r <= S_IDLE;
                pend_r <= prog_en_r;
                // Write-all gets the spare code 00, since its subcode 01 would alias a word write
                pend_kind_r <= (org16 ? hdr_r[9:8] : hdr_r[10:9]) == `SEPC_OP_WRITE ? `SEPC_OP_WRITE
                  : `SEPC_OP_EXT;
                pend_addr_r <= org16 ? {1'b0, hdr_r[7:0]} : hdr_r[8:0];
                pend_data_r <= org16 ? {wdata_r[14:0], di_s} : {wdata_r[6:0], di_s, 8'h00};
              end
            end
            S_READ:
            begin
              if (cnt_r == dat_len)
              begin
                // Next word follows at once, no dummy bit
                rd_addr_r <= addr_inc(rd_addr_r, last_addr);
                serial_data_out <= nxt_word[15];
                rd_sh_r <= {nxt_word[14:0], 1'b0};
                cnt_r <= 5'd1;
              end
              else
              begin
                serial_data_out <= rd_sh_r[15];
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
                cnt_r <= cnt_r + 5'd1;
              end
            end
            default:
              state_r <= S_IDLE;
          endcase
        end
      end
      // Cycle starts on the select falling edge
      if (cs_fall && pend_r)
        pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------
  // Array update runs inside the timed window: a word in one clock, or one byte per clock for the all-array sweep
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      timer_r <= 32'd0;
      sweep_r <= 9'h000;
      sweeping_r <= 1'b0;
      job_r <= 2'b00;
      job_addr_r <= 9'h000;
      job_data_r <= 16'h0000;
    end
    else if (cs_fall && pend_r && !busy)
    begin
      busy <= 1'b1;
      timer_r <= PROG_CYCLES;
      job_r <= pend_kind_r;
      job_addr_r <= pend_addr_r;
      job_data_r <= pend_data_r;
      sweeping_r <= 1'b1;
      sweep_r <= 9'h000;
    end
    else if (busy)
    begin
      if (sweeping_r)
      begin
        if (job_r == `SEPC_OP_WRITE || job_r == `SEPC_OP_ERASE)
        begin
          // Auto-clear: the new word replaces old contents directly
          if (org16)
          begin
            mem[{job_addr_r[7:0], 1'b0}] <= job_data_r[15:8];
            mem[{job_addr_r[7:0], 1'b1}] <= job_data_r[7:0];
          end
          else
            mem[job_addr_r] <= job_data_r[15:8];
          sweeping_r <= 1'b0;
        end
        else
        begin
          mem[sweep_r] <= (org16 && sweep_r[0]) ? job_data_r[7:0] : job_data_r[15:8];
          sweep_r <= sweep_r + 9'h001;
          if (sweep_r == 9'h1FF)
            sweeping_r <= 1'b0;
        end
      end
      if (timer_r <= 32'd1)
        busy <= 1'b0;
      timer_r <= timer_r - 32'd1;
    end
  end
endmodule // sepc_top

// ===== sim/sepc_checker_sva.sv
`timescale 1ns/1ps
module sepc_checker #(
  parameter PROG_CYCLES = 500000
) (
  input wire sys_clk, // Clock
  input wire rst, // Reset
  input wire chip_select, // Select pin
  input wire serial_clock_in, // Serial clock
  input wire serial_data_in, // Serial data in
  input wire word_width_select, // Organization
  input wire serial_data_out, // Data out
  input wire serial_data_oe, // Drive enable
  input wire busy // Programming
);
  reg [31:0] busy_cnt_r;
  always @(posedge sys_clk)
    busy_cnt_r <= (rst || !busy) ? 32'h0000_0000 : busy_cnt_r + 32'h0000_0001;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Output pin rules
  // ----------------------------------------
  a_idle_float: assert property ($fell(chip_select) ##1 !chip_select [*5] |-> !serial_data_oe)
    else $error("data out driven while deselected");
  a_oe_select: assert property ($rose(serial_data_oe) |-> chip_select && $past(chip_select, 2))
    else $error("data out driven without select");
  a_busy_low: assert property (serial_data_oe && busy |-> !serial_data_out)
    else $error("status not low while busy");
  a_ready_high: assert property ($fell(busy) && chip_select && serial_data_oe |-> ##[0:6] serial_data_out)
    else $error("status not high when ready");
  a_read_dummy: assert property ($rose(serial_data_oe) && !busy && !$past(busy) |-> !serial_data_out)
    else $error("first read bit not zero");
  a_out_on_rise: assert property ($changed(serial_data_out) && serial_data_oe && $past(serial_data_oe)
    && !busy && !$past(busy, 6) |-> serial_clock_in)
    else $error("read bit changed without serial rise");
  a_cycle_start: assert property ($rose(busy) |-> !chip_select && !$past(chip_select))
    else $error("cycle started while selected");
  a_self_timed: assert property ($rose(busy) |=> busy [*8])
    else $error("cycle ended at once");
  a_cycle_bound: assert property (busy_cnt_r < PROG_CYCLES + 16)
    else $error("cycle too long");
  c_cycle: cover property ($rose(busy));
  c_ready: cover property ($fell(busy) && serial_data_oe);
  c_read: cover property ($rose(serial_data_oe) && !busy);
endmodule // sepc_checker
bind sepc_top sepc_checker #(.PROG_CYCLES(PROG_CYCLES)) i_sepc_checker (.sys_clk(sys_clk), .rst(rst),
  .chip_select(chip_select), .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
  .word_width_select(word_width_select), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .busy(busy));

// ===== sim/sepc_ctrl_model.sv
`timescale 1ns/1ps
module sepc_ctrl_model (
  input wire sys_clk, // Clock
  input wire sdo, // Device data out
  input wire sdoe, // Device drive enable
  output reg cs, // Chip select
  output reg sclk, // Serial clock
  output reg sdi // Serial data
);
  reg [63:0] rx_r;
  reg st_r;
  reg rdy_r;
  reg fl_r;
  // Undriven line reads as z so a float never passes for data
  wire line = sdoe ? sdo : 1'bz;
  initial
  begin
    cs = 0;
    sclk = 0;
    sdi = 0;
  end
  task tick(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bits are taken at the end of the low phase, where they have settled
  task xfer(input [31:0] v, input integer n);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        sdi = v[i];
        tick(6);
        rx_r = {rx_r[62:0], line};
        sclk = 1;
        tick(6);
        sclk = 0;
      end
    end
  endtask
  task frame(input [31:0] v, input integer n);
    begin
      cs = 1;
      tick(3);
      xfer(v, n);
      cs = 0;
      tick(30);
    end
  endtask
  task read(input [31:0] v, input integer hn, input integer dn);
    begin
      cs = 1;
      tick(3);
      xfer(v, hn);
      xfer(0, dn);
      cs = 0;
      tick(30);
    end
  endtask
  task poll;
    integer k;
    begin
      cs = 1;
      tick(8);
      st_r = line;
      for (k = 0; k < 3000 && line !== 1'b1; k = k + 1)
        tick(1);
      rdy_r = line;
      xfer(1, 1);
      fl_r = sdoe;
      cs = 0;
      tick(30);
    end
  endtask
endmodule // sepc_ctrl_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam PROG = 2000;
  localparam LIMIT = 40000;
  reg sys_clk;
  reg rst;
  reg wide;
  wire cs;
  wire sclk;
  wire sdi;
  wire sdo;
  wire sdoe;
  wire busy;
  integer mismatches;
  integer checked;
  integer cycles;
  sepc_top #(.PROG_CYCLES(PROG)) i_sepc_top (.sys_clk(sys_clk), .rst(rst), .chip_select(cs), .serial_clock_in(sclk),
    .serial_data_in(sdi), .word_width_select(wide), .serial_data_out(sdo), .serial_data_oe(sdoe), .busy(busy));
  sepc_ctrl_model m (.sys_clk(sys_clk), .sdo(sdo), .sdoe(sdoe), .cs(cs), .sclk(sclk), .sdi(sdi));
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task check(input [63:0] exp, input [63:0] got, input [8*12-1:0] what);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  task do_reset;
    begin
      rst = 1;
      repeat (3) @(negedge sys_clk);
      rst = 0;
      repeat (4) @(negedge sys_clk);
    end
  endtask
  task poll_ok;
    begin
      m.poll;
      check(0, m.st_r, "busy level");
      check(1, m.rdy_r, "ready level");
      check(0, m.fl_r, "float");
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      m.frame({1'b1, 2'h1, a, d}, 27);
      poll_ok;
    end
  endtask
  task rd(input [7:0] a, input [32:0] exp);
    begin
      m.read({1'b1, 2'h2, a}, 11, 33);
      check(exp, m.rx_r[32:0], "read burst");
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_protect;
    begin
      m.frame({1'b1, 2'h1, 8'h03, 16'h0000}, 27);
      check(0, busy, "busy");
      $display("protect done");
    end
  endtask
  task t_erase_all;
    begin
      m.frame({1'b1, 2'h0, 2'h3, 6'h00}, 11);
      m.frame({1'b1, 2'h0, 2'h2, 6'h00}, 11);
      poll_ok;
      rd(8'h80, {1'b0, 32'hFFFF_FFFF});
      $display("erase all done");
    end
  endtask
  task t_write;
    begin
      wr(8'h03, 16'hA5C3);
      wr(8'h04, 16'h0F0F);
      wr(8'h00, 16'h1357);
      rd(8'h03, {1'b0, 32'hA5C3_0F0F});
      rd(8'hFF, {1'b0, 32'hFFFF_1357});
      wr(8'h03, 16'h1234);
      m.frame({1'b1, 2'h3, 8'h04}, 11);
      poll_ok;
      rd(8'h03, {1'b0, 32'h1234_FFFF});
      $display("write done");
    end
  endtask
  task t_disable;
    begin
      m.frame({1'b1, 2'h0, 2'h0, 6'h00}, 11);
      m.frame({1'b1, 2'h1, 8'h03, 16'h0000}, 27);
      check(0, busy, "busy");
      m.frame(5'h18, 5);
      rd(8'h03, {1'b0, 32'h1234_FFFF});
      $display("disable done");
    end
  endtask
  task t_narrow;
    begin
      wide = 0;
      do_reset;
      m.frame({1'b1, 2'h0, 2'h3, 7'h00}, 12);
      m.frame({1'b1, 2'h1, 9'h007, 8'h5A}, 20);
      poll_ok;
      m.read({1'b1, 2'h2, 9'h007}, 12, 17);
      check({1'b0, 8'h5A, 8'hFF}, m.rx_r[16:0], "byte burst");
      $display("narrow done");
    end
  endtask
  initial
  begin
    mismatches = 0;
    checked = 0;
    cycles = 0;
    wide = 1;
    rst = 1;
    do_reset;
    t_protect;
    t_erase_all;
    t_write;
    t_disable;
    t_narrow;
    end_of_test;
  end
endmodule // testbench
